// ==== src/mss_params.svh ====
// Timing constants and reset values for the magnetic switch output and self-test logic.
`ifndef MSS_PARAMS_SVH
`define MSS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MSS_CLK_PERIOD_NS 50
`define MSS_REFRESH_NS 2000
`define MSS_REFRESH_CYC ((`MSS_REFRESH_NS) / (`MSS_CLK_PERIOD_NS))
`define MSS_WIN1_CYC 4000
`define MSS_WIN2_CYC 4000
`define MSS_WAKE_CYC 2
`define MSS_CNT_W 16

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MSS_SWITCH_RST 1'b0

`endif

// ==== src/mss_pkg.sv ====
// Types shared by the magnetic switch output and self-test logic.
package mss_pkg;

  typedef enum logic [4:0] {
    MSS_ARM = 5'h01,
    MSS_SEEN_LOW = 5'h02,
    MSS_WIN1 = 5'h04,
    MSS_WIN2 = 5'h08,
    MSS_NORMAL = 5'h10
  } mss_st_t;

endpackage

// ==== src/mss_sync.sv ====
// Two-flop synchroniser for a group of asynchronous level inputs.
`timescale 1ns/100ps
module mss_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule // mss_sync

// ==== src/mss_top.sv ====
// Output control and power-on self-test of a three-pin magnetic-field switch.
`timescale 1ns/100ps
`include "mss_params.svh"
module mss_top #(
  parameter int unsigned WIN1_CYC = `MSS_WIN1_CYC,
  parameter int unsigned WIN2_CYC = `MSS_WIN2_CYC
) (
  // Clock and reset; reset_n is the power-on reset of supply_pin.
  input wire logic clk,
  input wire logic reset_n,
  // Comparator results from the analog front end.
  input wire logic above_on_thr,
  input wire logic below_off_thr,
  // Fault monitors.
  input wire logic overtemp,
  input wire logic undervolt,
  input wire logic reg_volt_err,
  input wire logic bias_err,
  input wire logic vref_err,
  input wire logic plate_err,
  // Open-drain output pin.
  input wire logic out_in,
  output logic out_o,
  output logic out_oe,
  // Status.
  output logic selftest_active,
  output logic selftest_done
);

  // --------------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------------
  localparam int NS = 9;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn;

  assign raw_in = {out_in, plate_err, vref_err, bias_err, reg_volt_err, undervolt, overtemp,
                   below_off_thr, above_on_thr};

  mss_sync #(.W(NS)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(raw_in),
    .sync_out(syn)
  );

  logic on_s;
  logic off_s;
  logic fault_s;
  logic pin_s;

  assign on_s = syn[0];
  assign off_s = syn[1];
  assign fault_s = |syn[7:2];
  assign pin_s = syn[8];

  // --------------------------------------------------------------------------
  // Sampling and hysteresis
  // --------------------------------------------------------------------------
  localparam logic [`MSS_CNT_W-1:0] REFRESH_LAST = `MSS_CNT_W'(`MSS_REFRESH_CYC - 1);
  logic [`MSS_CNT_W-1:0] smp_cnt_q;
  logic [`MSS_CNT_W-1:0] smp_cnt_d;
  logic switch_q;
  logic switch_d;

  always_comb begin
    smp_cnt_d = smp_cnt_q + `MSS_CNT_W'(1);
    switch_d = switch_q;
    if (smp_cnt_q == REFRESH_LAST) begin
      smp_cnt_d = '0;
      // Between the two thresholds the last decision holds, which gives hysteresis.
      if (on_s) begin
        switch_d = 1'b1;
      end else if (off_s) begin
        switch_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      smp_cnt_q <= '0;
      switch_q <= `MSS_SWITCH_RST;
    end else begin
      smp_cnt_q <= smp_cnt_d;
      switch_q <= switch_d;
    end
  end

  // --------------------------------------------------------------------------
  // Self-test sequencer
  // --------------------------------------------------------------------------
  localparam logic [`MSS_CNT_W-1:0] WIN1_LAST = `MSS_CNT_W'(WIN1_CYC - 1);
  localparam logic [`MSS_CNT_W-1:0] WIN2_LAST = `MSS_CNT_W'(WIN2_CYC - 1);
  mss_pkg::mss_st_t st_q;
  mss_pkg::mss_st_t st_d;
  logic [`MSS_CNT_W-1:0] win_cnt_q;
  logic [`MSS_CNT_W-1:0] win_cnt_d;
  localparam logic [1:0] WAKE_LAST = 2'(`MSS_WAKE_CYC);
  logic [1:0] wake_cnt_q;
  logic [1:0] wake_cnt_d;

  always_comb begin
    st_d = st_q;
    win_cnt_d = '0;
    wake_cnt_d = wake_cnt_q;
    case (st_q)
      mss_pkg::MSS_ARM: begin
        // The synchroniser wakes up at zero, which would read as a held line.
        // Waiting until it carries the real pin level stops a bare release from starting the test.
        if (wake_cnt_q != WAKE_LAST) begin
          wake_cnt_d = wake_cnt_q + 2'h1;
        end else if (!pin_s) begin
          st_d = mss_pkg::MSS_SEEN_LOW;
        end else begin
          st_d = mss_pkg::MSS_NORMAL;
        end
      end
      mss_pkg::MSS_SEEN_LOW: begin
        if (pin_s) begin
          st_d = mss_pkg::MSS_WIN1;
        end
      end
      mss_pkg::MSS_WIN1: begin
        win_cnt_d = win_cnt_q + `MSS_CNT_W'(1);
        if (win_cnt_q == WIN1_LAST) begin
          win_cnt_d = '0;
          st_d = mss_pkg::MSS_WIN2;
        end
      end
      mss_pkg::MSS_WIN2: begin
        win_cnt_d = win_cnt_q + `MSS_CNT_W'(1);
        if (win_cnt_q == WIN2_LAST) begin
          win_cnt_d = '0;
          st_d = mss_pkg::MSS_NORMAL;
        end
      end
      mss_pkg::MSS_NORMAL: begin
        st_d = mss_pkg::MSS_NORMAL;
      end
      default: begin
        st_d = mss_pkg::MSS_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= mss_pkg::MSS_ARM;
      win_cnt_q <= '0;
      wake_cnt_q <= '0;
    end else begin
      st_q <= st_d;
      win_cnt_q <= win_cnt_d;
      wake_cnt_q <= wake_cnt_d;
    end
  end

  // --------------------------------------------------------------------------
  // Open-drain output stage
  // --------------------------------------------------------------------------
  logic drive_low_q;
  logic drive_low_d;

  always_comb begin
    case (st_q)
      mss_pkg::MSS_WIN1: drive_low_d = 1'b1;
      mss_pkg::MSS_WIN2: drive_low_d = 1'b0;
      mss_pkg::MSS_NORMAL: drive_low_d = switch_q & ~fault_s;
      default: drive_low_d = 1'b0;
    endcase
    // Faults also win over the self-test so the safe state is never masked.
    if (fault_s) begin
      drive_low_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_low_q <= 1'b0;
    end else begin
      drive_low_q <= drive_low_d;
    end
  end

  assign out_o = 1'b0;
  assign out_oe = drive_low_q;
  assign selftest_active = (st_q == mss_pkg::MSS_WIN1) || (st_q == mss_pkg::MSS_WIN2);
  assign selftest_done = (st_q == mss_pkg::MSS_NORMAL);

endmodule // mss_top

// ==== verif/mss_top_assertions.sv ====
// Port checks for the magnetic switch top.
`timescale 1ns/100ps
module mss_top_assertions #(
  parameter int unsigned WIN1_CYC = 8,
  parameter int unsigned WIN2_CYC = 8
) (
  // Clock, reset, field and faults
  input wire logic clk,
  input wire logic reset_n,
  input wire logic above_on_thr,
  input wire logic below_off_thr,
  input wire logic overtemp,
  input wire logic undervolt,
  input wire logic reg_volt_err,
  input wire logic bias_err,
  input wire logic vref_err,
  input wire logic plate_err,
  // Output and status
  input wire logic out_oe,
  input wire logic selftest_active,
  input wire logic selftest_done
);
  wire flt = overtemp | undervolt | reg_volt_err | bias_err | vref_err | plate_err;
  int unsigned cnt_q;
  int unsigned cnt_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Counting test cycles pins both window edges to an exact cycle.
  always_comb cnt_d = cnt_q + selftest_active;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cnt_q <= 0;
    else cnt_q <= cnt_d;
  end
  a_fault_release: assert property (flt[*4] |-> !out_oe)
    else $error("fault kept pull");
  a_wake_released: assert property (!selftest_active && !selftest_done |-> !out_oe)
    else $error("pull before test");
  a_win1_low: assert property (selftest_active && cnt_q >= 1 && cnt_q <= WIN1_CYC |-> out_oe)
    else $error("first window not low");
  a_win2_high: assert property (selftest_active && cnt_q > WIN1_CYC |-> !out_oe)
    else $error("second window not high");
  a_test_end: assert property ($fell(selftest_active) |-> selftest_done && cnt_q == WIN1_CYC + WIN2_CYC)
    else $error("bad test length");
  a_test_once: assert property (selftest_done |=> selftest_done && !selftest_active)
    else $error("test rerun");
  a_rise_cause: assert property ($rose(out_oe) && selftest_done |-> $past(above_on_thr, 4) && !flt)
    else $error("pull without field");
  a_fall_cause: assert property ($fell(out_oe) && selftest_done |-> flt || $past(below_off_thr, 4))
    else $error("release without cause");
endmodule // mss_top_assertions
bind mss_top mss_top_assertions #(.WIN1_CYC(WIN1_CYC), .WIN2_CYC(WIN2_CYC)) u_chk (.*);

// ==== verif/mss_host.sv ====
// Host model: switches sensor power and shares the pulled-up output wire.
`timescale 1ns/100ps
module mss_host (
  // Clock
  input wire logic clk,
  // Sensor output drive
  input wire logic out_o,
  input wire logic out_oe,
  // Sensor supply and wire level
  output logic reset_n,
  output logic line
);
  logic pwr_q = 1'b0;
  logic hold_q = 1'b0;
  assign reset_n = pwr_q;
  // The pull-up wins only when neither party pulls; each sensor gets its own wire.
  assign line = ((out_oe && !out_o) || hold_q) ? 1'b0 : 1'b1;
  task power_cycle;
    @(posedge clk);
    #5 pwr_q = 1'b0;
    @(posedge clk);
    #5 hold_q = 1'b1;
    repeat (15) @(posedge clk);
    #5 pwr_q = 1'b1;
    repeat (4) @(posedge clk);
    #5 hold_q = 1'b0;
  endtask
  task power_plain;
    @(posedge clk);
    #5 pwr_q = 1'b0;
    repeat (16) @(posedge clk);
    #5 pwr_q = 1'b1;
  endtask
  task hold_line;
    @(posedge clk);
    #5 hold_q = 1'b1;
    repeat (10) @(posedge clk);
    #5 hold_q = 1'b0;
  endtask
endmodule // mss_host

// ==== verif/mss_top_tb.sv ====
// Self-checking bench for the magnetic switch output and self-test logic.
`timescale 1ns/100ps
module mss_top_tb;
  localparam int unsigned W1 = 8;
  localparam int unsigned W2 = 8;
  logic clk = 1'b0;
  logic above_on_thr = 1'b0;
  logic below_off_thr = 1'b0;
  logic [5:0] flt = 6'h00;
  logic sw = 1'b0;
  int err_count = 0;
  int comparisons = 0;
  int seed = 32'h2BD7;
  int r;
  wire reset_n, line, out_o, out_oe, selftest_active, selftest_done;
  always #25 clk = ~clk;
  mss_top #(.WIN1_CYC(W1), .WIN2_CYC(W2)) DUT (.clk(clk), .reset_n(reset_n), .above_on_thr(above_on_thr),
    .below_off_thr(below_off_thr), .overtemp(flt[0]), .undervolt(flt[1]), .reg_volt_err(flt[2]),
    .bias_err(flt[3]), .vref_err(flt[4]), .plate_err(flt[5]), .out_in(line), .out_o(out_o), .out_oe(out_oe),
    .selftest_active(selftest_active), .selftest_done(selftest_done));
  mss_host HOST (.clk(clk), .out_o(out_o), .out_oe(out_oe), .reset_n(reset_n), .line(line));
  task automatic chk(input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic run_test;
    int n;
    n = 0;
    HOST.power_cycle();
    while (selftest_active !== 1'b1) begin
      tick();
      n++;
      if (n > 100) begin
        err_count++;
        wrap_up();
      end
    end
    for (int i = 0; i < W1 + W2; i++) begin
      tick();
      chk(line, i >= W1);
    end
    tick();
    chk(selftest_done, 1'b1);
  endtask
  initial begin
    run_test();
    HOST.hold_line();
    repeat (20) begin
      tick();
      chk(selftest_active, 1'b0);
    end
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      #4 {above_on_thr, below_off_thr} = r[1:0];
      sw = r[1] | (sw & ~r[0]);
      repeat (50) tick();
      chk(out_oe, sw);
    end
    #4 above_on_thr = 1'b1;
    below_off_thr = 1'b0;
    repeat (50) tick();
    for (int k = 0; k < 6; k++) begin
      #4 flt = 6'h01 << k;
      repeat (4) tick();
      chk(out_oe, 1'b0);
      #4 flt = 6'h00;
      repeat (50) tick();
      chk(out_oe, 1'b1);
    end
    run_test();
    repeat (50) tick();
    chk(out_oe, 1'b1);
    HOST.power_plain();
    repeat (40) begin
      tick();
      chk(selftest_active, 1'b0);
    end
    chk(selftest_done, 1'b1);
    wrap_up();
  end
endmodule // mss_top_tb
